// ### ctg_pkg.sv
package ctg_pkg;
    // Trigger source select
    typedef enum logic [1:0] {
        CTG_SRC_EXT = 2'h0,
        CTG_SRC_SW = 2'h1,
        CTG_SRC_TIMER = 2'h2
    } ctg_src_t;

    // Port function select
    typedef enum logic [2:0] {
        CTG_PF_OFF = 3'h0,
        CTG_PF_TRIG_IN = 3'h1,
        CTG_PF_CLK_IN = 3'h2,
        CTG_PF_OUT_LVL = 3'h3,
        CTG_PF_OUT_OC = 3'h4
    } ctg_pfunc_t;

    // Delay sequencer states
    typedef enum logic [1:0] {
        CTG_DLY_IDLE = 2'h0,
        CTG_DLY_RUN = 2'h1,
        CTG_DLY_WAIT_LOW = 2'h2
    } ctg_dly_t;

    // Drive of one user port
    typedef struct packed {
        logic out;
        logic oe_b;
    } ctg_pin_t;

    localparam int CTG_CLK_NS = 100;
    localparam int CTG_TICK_NS = 100;
    localparam int CTG_TICK_CYC = (CTG_TICK_NS + CTG_CLK_NS - 1) / CTG_CLK_NS;
    localparam int CTG_MIN_PULSE_US = 16;
    localparam int CTG_MIN_PULSE_CYC = (CTG_MIN_PULSE_US * 1000) / CTG_CLK_NS;
    localparam logic [31:0] CTG_RST_INTERVAL = 32'h0000_0000;
    localparam logic [31:0] CTG_RST_DELAY = 32'h0000_0000;
    localparam logic [31:0] CTG_CNT_ZERO = 32'h0000_0000;
    localparam logic [31:0] CTG_CNT_ONE = 32'h0000_0001;
endpackage : ctg_pkg

// ### ctg_src_model.sv
`timescale 1ns/1ps
module ctg_src_model (
    // Clock
    input wire logic i_clk,
    // Requests from the bench
    input wire logic i_pulse_req,
    input wire logic i_clk_run,
    // Pins toward the block
    output logic [1:0] o_pin
);
    int hold = 0;
    int ph = 0;
    initial o_pin = 2'h0;
    always @(posedge i_clk) begin
        if (i_pulse_req) begin
            hold = 200;
        end
        o_pin[0] <= hold > 0;
        if (hold > 0) begin
            hold--;
        end
        ph = (ph + 1) % 10;
        o_pin[1] <= i_clk_run && ph < 5;
    end
endmodule : ctg_src_model

// ### ctg_trigger_gen.sv
// Function
// R1 - three sources, exactly one active
// R2 - 32-bit timer counting 100 ns units
// R3 - interval input sets timer period
// R4 - at interval, pulse and restart timer
// R5 - external trigger from trigger-input port
// R6 - external pulses last at least 16 us
// R7 - programmable delay after external trigger
// R8 - delay timebase internal or external clock
// R9 - external mode: only external trigger exposes
// R10 - software mode: only request triggers
// R11 - each port independently trigger-configurable
// R12 - per-port function: trig, clk, output
// R13 - source change clears timer and delay
// R14 - output port mirrors every trigger pulse
`timescale 1ns/1ps
module ctg_trigger_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Configuration
    input wire ctg_pkg::ctg_src_t i_source,
    input wire logic [31:0] i_interval,
    input wire logic [31:0] i_external_trigger_delay_time,
    input wire logic i_ext_clk_sel,
    input wire ctg_pkg::ctg_pfunc_t i_port1_function_select,
    input wire ctg_pkg::ctg_pfunc_t i_port2_function_select,
    // Software request, one-cycle pulse
    input wire logic i_sw_trig,
    // User port pins
    input wire logic [1:0] i_port_pin,
    output logic [1:0] o_port_out,
    output logic [1:0] o_port_oe_b,
    // Exposure trigger and status
    output logic o_trig,
    output logic o_dly_busy
);
    logic [1:0] sync1;
    logic [1:0] sync2;
    ctg_pkg::ctg_src_t src_q;
    logic src_chg;
    logic [31:0] tmr;
    logic [1:0] tick_cnt;
    logic tick;
    logic tmr_hit;
    ctg_pkg::ctg_dly_t dly_st;
    logic [31:0] dly_cnt;
    logic ext_trig_lvl;
    logic ext_trig_rise;
    logic ext_trig_q;
    logic ext_clk_lvl;
    logic ext_clk_q;
    logic dly_step;
    logic dly_fire;
    logic next_trig;
    ctg_pkg::ctg_pfunc_t pfunc [2];
    ctg_pkg::ctg_pin_t pin_drv [2];

    function automatic logic sel_port(input ctg_pkg::ctg_pfunc_t f0,
                                      input ctg_pkg::ctg_pfunc_t f1,
                                      input ctg_pkg::ctg_pfunc_t want,
                                      input logic [1:0] lvl);
        sel_port = ((f0 == want) & lvl[0]) | ((f1 == want) & lvl[1]);
    endfunction : sel_port

    assign pfunc[0] = i_port1_function_select;
    assign pfunc[1] = i_port2_function_select;

    // Pins are asynchronous: two flops before use
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= i_port_pin;
            sync2 <= sync1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ext_trig_q <= 1'b0;
            ext_clk_q <= 1'b0;
        end else begin
            ext_trig_q <= ext_trig_lvl;
            ext_clk_q <= ext_clk_lvl;
        end
    end

    // R5 pick trigger port
    assign ext_trig_lvl = sel_port(pfunc[0], pfunc[1], ctg_pkg::CTG_PF_TRIG_IN, sync2);
    assign ext_clk_lvl = sel_port(pfunc[0], pfunc[1], ctg_pkg::CTG_PF_CLK_IN, sync2);
    assign ext_trig_rise = ext_trig_lvl & ~ext_trig_q;

    // R13 source change detect
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            src_q <= ctg_pkg::CTG_SRC_EXT;
        end else begin
            src_q <= i_source;
        end
    end
    assign src_chg = (src_q != i_source);

    // R2 100 ns timebase
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || src_chg) begin
            tick_cnt <= 2'h0;
        end else if (tick) begin
            tick_cnt <= 2'h0;
        end else begin
            tick_cnt <= tick_cnt + 2'h1;
        end
    end
    assign tick = (tick_cnt == 2'(ctg_pkg::CTG_TICK_CYC - 1));

    // R3 compare with interval
    assign tmr_hit = tick && (tmr + ctg_pkg::CTG_CNT_ONE >= i_interval)
                     && (i_interval != ctg_pkg::CTG_CNT_ZERO);

    // R4 periodic reload
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || src_chg || i_source != ctg_pkg::CTG_SRC_TIMER) begin
            tmr <= ctg_pkg::CTG_CNT_ZERO;
        end else if (tmr_hit) begin
            tmr <= ctg_pkg::CTG_CNT_ZERO;
        end else if (tick) begin
            tmr <= tmr + ctg_pkg::CTG_CNT_ONE;
        end
    end

    // R8 delay timebase select
    assign dly_step = i_ext_clk_sel ? (ext_clk_lvl & ~ext_clk_q) : tick;

    // R7 delay sequencer
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || src_chg || i_source != ctg_pkg::CTG_SRC_EXT) begin
            dly_st <= ctg_pkg::CTG_DLY_IDLE;
            dly_cnt <= ctg_pkg::CTG_CNT_ZERO;
        end else begin
            case (dly_st)
                ctg_pkg::CTG_DLY_IDLE: begin
                    if (ext_trig_rise) begin
                        dly_cnt <= ctg_pkg::CTG_CNT_ZERO;
                        dly_st <= ctg_pkg::CTG_DLY_RUN;
                    end
                end
                ctg_pkg::CTG_DLY_RUN: begin
                    if (dly_fire) begin
                        dly_st <= ctg_pkg::CTG_DLY_WAIT_LOW;
                    end else if (dly_step) begin
                        dly_cnt <= dly_cnt + ctg_pkg::CTG_CNT_ONE;
                    end
                end
                ctg_pkg::CTG_DLY_WAIT_LOW: begin
                    // Re-arm only after the pulse ends; one exposure per pulse
                    if (!ext_trig_lvl) begin
                        dly_st <= ctg_pkg::CTG_DLY_IDLE;
                    end
                end
                default: begin
                    dly_st <= ctg_pkg::CTG_DLY_IDLE;
                end
            endcase
        end
    end
    assign dly_fire = (dly_st == ctg_pkg::CTG_DLY_RUN)
                      && (dly_cnt >= i_external_trigger_delay_time);

    // R1 one source gates output
    always_comb begin
        next_trig = 1'b0;
        if (!src_chg) begin
            case (i_source)
                // R9 external only
                ctg_pkg::CTG_SRC_EXT: next_trig = dly_fire;
                // R10 software only
                ctg_pkg::CTG_SRC_SW: next_trig = i_sw_trig;
                ctg_pkg::CTG_SRC_TIMER: next_trig = tmr_hit;
                default: next_trig = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_trig <= 1'b0;
            o_dly_busy <= 1'b0;
        end else begin
            o_trig <= next_trig;
            o_dly_busy <= (dly_st != ctg_pkg::CTG_DLY_IDLE) && !src_chg;
        end
    end

    // R11 independent port drivers
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_port
            // R12 per-port function
            always_comb begin
                pin_drv[gi].out = 1'b0;
                pin_drv[gi].oe_b = 1'b1;
                case (pfunc[gi])
                    ctg_pkg::CTG_PF_OUT_LVL: begin
                        pin_drv[gi].out = next_trig;
                        pin_drv[gi].oe_b = 1'b0;
                    end
                    ctg_pkg::CTG_PF_OUT_OC: begin
                        // Open collector: pull low while pulsing, else release
                        pin_drv[gi].out = 1'b0;
                        pin_drv[gi].oe_b = ~next_trig;
                    end
                    default: begin
                        pin_drv[gi].out = 1'b0;
                        pin_drv[gi].oe_b = 1'b1;
                    end
                endcase
            end
            // R14 mirror trigger pulse
            always_ff @(posedge i_clk) begin
                if (!i_rst_b) begin
                    o_port_out[gi] <= 1'b0;
                    o_port_oe_b[gi] <= 1'b1;
                end else begin
                    o_port_out[gi] <= pin_drv[gi].out;
                    o_port_oe_b[gi] <= pin_drv[gi].oe_b;
                end
            end
        end
    endgenerate

    // Pulse width counter for the external input, checked below
    logic [15:0] hi_cnt;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            hi_cnt <= 16'h0000;
        end else if (ext_trig_lvl) begin
            hi_cnt <= (hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h0001;
        end else begin
            hi_cnt <= 16'h0000;
        end
    end

    property p_one_src;
        @(posedge i_clk) disable iff (!i_rst_b)
        o_trig |-> $past(i_source) == $past(src_q);
    endproperty
    a_one_src: assert property (p_one_src) else $error("trigger during source change"); // R1

    property p_tmr_count;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_source == ctg_pkg::CTG_SRC_TIMER && !src_chg && tick && !tmr_hit)
        ##1 (i_source == ctg_pkg::CTG_SRC_TIMER) |-> tmr == $past(tmr) + 32'h0000_0001;
    endproperty
    a_tmr_count: assert property (p_tmr_count) else $error("timer did not advance"); // R2

    property p_tmr_period;
        @(posedge i_clk) disable iff (!i_rst_b)
        // A hit outside timer mode, past the switch cycle, only means interval is 1 and the timer is parked
        (tmr_hit && !src_chg && i_source == ctg_pkg::CTG_SRC_TIMER)
        |=> (tmr == 32'h0000_0000 && o_trig);
    endproperty
    a_tmr_period: assert property (p_tmr_period) else $error("timer reload failed"); // R4

    property p_tmr_bound;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_interval != 32'h0000_0000 && $stable(i_interval)) |-> tmr < i_interval;
    endproperty
    a_tmr_bound: assert property (p_tmr_bound) else $error("timer passed interval"); // R3

    property p_min_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(ext_trig_lvl) |-> $past(hi_cnt) >= 16'(ctg_pkg::CTG_MIN_PULSE_CYC);
    endproperty
    a_min_pulse: assert property (p_min_pulse) else $error("external pulse too short"); // R6

    property p_ext_only;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_trig && $past(i_source) == ctg_pkg::CTG_SRC_EXT) |-> $past(dly_fire);
    endproperty
    a_ext_only: assert property (p_ext_only) else $error("external mode stray trigger"); // R9

    property p_sw_only;
        @(posedge i_clk) disable iff (!i_rst_b)
        (o_trig && $past(i_source) == ctg_pkg::CTG_SRC_SW) |-> $past(i_sw_trig);
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("software mode stray trigger"); // R10

    property p_chg_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        src_chg |=> (tmr == 32'h0000_0000 && dly_st == ctg_pkg::CTG_DLY_IDLE);
    endproperty
    a_chg_clear: assert property (p_chg_clear) else $error("source change left state"); // R13

    property p_mirror;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_port1_function_select == ctg_pkg::CTG_PF_OUT_LVL && next_trig)
        |=> (o_port_out[0] && !o_port_oe_b[0] && o_trig);
    endproperty
    a_mirror: assert property (p_mirror) else $error("port 1 missed trigger"); // R14

    property p_oc_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
        (i_port2_function_select == ctg_pkg::CTG_PF_OUT_OC)
        |=> (o_port_oe_b[1] == !$past(next_trig) && !o_port_out[1]);
    endproperty
    a_oc_pulse: assert property (p_oc_pulse) else $error("port 2 open collector wrong"); // R12
endmodule : ctg_trigger_gen

// ### tb_ctg_trigger_gen.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_ctg_trigger_gen;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    ctg_pkg::ctg_src_t src = ctg_pkg::CTG_SRC_SW;
    logic [31:0] intv = 32'h0;
    logic [31:0] dly = 32'h0;
    logic [31:0] r;
    logic csel = 1'b0;
    ctg_pkg::ctg_pfunc_t f1 = ctg_pkg::CTG_PF_TRIG_IN;
    ctg_pkg::ctg_pfunc_t f2 = ctg_pkg::CTG_PF_OUT_LVL;
    logic sw = 1'b0;
    logic req = 1'b0;
    logic crun = 1'b0;
    logic ign = 1'b0;
    logic [1:0] pin;
    logic [1:0] pout;
    logic [1:0] poe_b;
    logic trig;
    logic busy;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 88;
    int cyc = 0;
    int last = 0;
    int seen = 0;
    int t0;
    int q[$];
    ctg_src_model ctg_src_model_i (.i_clk(clk), .i_pulse_req(req), .i_clk_run(crun),
        .o_pin(pin));
    ctg_trigger_gen ctg_trigger_gen_i (.i_clk(clk), .i_rst_b(rst_b), .i_source(src),
        .i_interval(intv), .i_external_trigger_delay_time(dly), .i_ext_clk_sel(csel),
        .i_port1_function_select(f1), .i_port2_function_select(f2), .i_sw_trig(sw),
        .i_port_pin(pin), .o_port_out(pout), .o_port_oe_b(poe_b), .o_trig(trig),
        .o_dly_busy(busy));
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic chk_port(input int p);
        ctg_pkg::ctg_pfunc_t f;
        f = p ? f2 : f1;
        if (f == ctg_pkg::CTG_PF_OUT_LVL || f == ctg_pkg::CTG_PF_OUT_OC) begin
            `CHK(pout[p], trig & (f == ctg_pkg::CTG_PF_OUT_LVL))
            if (trig) `CHK(poe_b[p], 1'b0)
        end else if (trig) begin
            `CHK(poe_b[p], 1'b1)
        end
    endtask : chk_port
    // Result watcher: every pulse while ign is low must match the oldest note
    always @(negedge clk) begin
        if (rst_b && trig === 1'b1) begin
            last = cyc;
            seen++;
            if (!ign && q.size() == 0) begin
                `CHK(trig, 1'b0)
            end else if (!ign) begin
                `CHK(cyc, q.pop_front())
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (rst_b) chk_port(p);
        end
    end
    task automatic do_reset();
        rst_b = 1'b0;
        tick(10);
        `CHK({trig, busy, pout, poe_b}, 6'h03)
        rst_b = 1'b1;
    endtask : do_reset
    task automatic drain();
        int n;
        n = 0;
        while (q.size() != 0 && n < 400) begin
            tick(1);
            n++;
        end
        if (q.size() != 0) begin
            fail_count++;
            complete_run();
        end
    endtask : drain
    task automatic wait_trig();
        int s;
        int n;
        s = seen;
        n = 0;
        while (seen == s && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (seen == s) begin
            fail_count++;
            complete_run();
        end
    endtask : wait_trig
    task automatic ext_pulse(input logic note);
        req = 1'b1;
        if (note) q.push_back(cyc + 5 + int'(dly));
        tick(1);
        req = 1'b0;
    endtask : ext_pulse
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    initial begin
        do_reset();
        tick(3);
        ext_pulse(1'b0);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            sw = r[0];
            if (sw) q.push_back(cyc + 1);
            tick(1);
        end
        sw = 1'b0;
        drain();
        tick(200);
        f1 = ctg_pkg::CTG_PF_OUT_LVL;
        f2 = ctg_pkg::CTG_PF_OUT_OC;
        r = $random(seed);
        intv = {29'h0, r[2:0]} + 32'h3;
        src = ctg_pkg::CTG_SRC_TIMER;
        // First pulse one interval plus one cycle after the source switch, then one per interval
        for (int i = 1; i < 6; i++) q.push_back(cyc + 1 + i * int'(intv));
        drain();
        src = ctg_pkg::CTG_SRC_EXT;
        f1 = ctg_pkg::CTG_PF_TRIG_IN;
        f2 = ctg_pkg::CTG_PF_OUT_LVL;
        tick(3);
        for (int i = 0; i < 3; i++) begin
            r = $random(seed);
            dly = {29'h0, r[2:0]};
            ext_pulse(1'b1);
            sw = 1'b1;
            tick(1);
            sw = 1'b0;
            drain();
            tick(200);
        end
        dly = 32'h3C;
        ext_pulse(1'b0);
        tick(20);
        `CHK(busy, 1'b1)
        src = ctg_pkg::CTG_SRC_SW;
        tick(3);
        `CHK(busy, 1'b0)
        tick(250);
        src = ctg_pkg::CTG_SRC_EXT;
        f2 = ctg_pkg::CTG_PF_CLK_IN;
        csel = 1'b1;
        crun = 1'b1;
        dly = 32'h3;
        tick(3);
        ign = 1'b1;
        t0 = cyc;
        ext_pulse(1'b0);
        wait_trig();
        `CHK(last - t0 >= 20 && last - t0 <= 45, 1'b1)
        ign = 1'b0;
        crun = 1'b0;
        tick(250);
        do_reset();
        complete_run();
    end
endmodule : tb_ctg_trigger_gen
